// [rtl/ccmc_top.sv]
/*
 * Mode decode, time-base selection, special-event trigger and pin handling for two
 * capture/compare/PWM units, with their registers behind an APB slave.
 * Assumes counter values, counter-two period match, counter-three write and wrap and the
 * converter enable arrive from logic on clk_i; the port pins are asynchronous.
 */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE_01 - Unit two trigger clears counter three, starts conversion; here it clears counter one when assign field 00 gives unit two counter one
// RULE_02 - Counter three must run synchronous for resets
// RULE_03 - Counter three write beats trigger clear
// RULE_04 - Trigger clear never sets counter-three overflow flag
// RULE_05 - Each unit holds one 16-bit data register
// RULE_06 - Control bits 7 and 6 read zero
// RULE_07 - Duty low bits used only in PWM
// RULE_08 - Mode zero resets unit; 0001, 0011 reserved
// RULE_09 - Toggle mode inverts pin, sets flag
// RULE_10 - Capture on fall, rise, fourth, sixteenth rise
// RULE_11 - Mode 1000 starts low, match drives high
// RULE_12 - Mode 1001 starts high, match drives low
// RULE_13 - Mode 1010 only sets flag on match
// RULE_14 - Mode 1011 sets flag, pulses special trigger
// RULE_15 - Modes 11xx are PWM on counter two
// RULE_16 - Capture/compare use counter one or three
// RULE_17 - Both units run together, may share
// RULE_18 - No capture with counter one asynchronous
// RULE_19 - Route bit picks default or alternate pin
// RULE_20 - Software sets direction of routed pin; here unit two's mode sets its output enable
// RULE_21 - Only unit two trigger starts conversion
// RULE_22 - PWM units share counter two period event
// RULE_23 - Assign field 1x, 01, 00 selects counters
// RULE_24 - Capture sets sticky flag, overwrites old value
module ccmc_top (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic [15:0] counter_one_i,
	input  wire logic [15:0] counter_three_i,
	input  wire logic [9:0]  counter_two_i,
	input  wire logic        counter_two_match_i,
	input  wire logic        counter_three_write_i,
	input  wire logic        counter_three_wrap_i,
	input  wire logic        adc_enabled_i,
	input  wire logic        unit_one_pin_i,
	input  wire logic        default_port_pin_i,
	input  wire logic        alternate_port_pin_i,
	output logic             unit_one_pin_o,
	output logic             unit_one_pin_oe_o,
	output logic             default_port_pin_o,
	output logic             default_port_pin_oe_o,
	output logic             alternate_port_pin_o,
	output logic             alternate_port_pin_oe_o,
	output logic             counter_one_clear_o,
	output logic             counter_three_clear_o,
	output logic             adc_start_o,
	output logic             counter_three_overflow_flag_o
);
	logic                      pready_r;
	logic [31:0]               prdata_r;
	logic                      pslverr_r;
	logic [1:0]                cfg_tb_r;
	logic                      route_r;
	logic [2:0]                stat_r;
	logic [2:0]                pin_meta_r;
	logic [2:0]                pin_sync_r;
	logic                      ctr1_clear_r;
	logic                      ctr3_clear_r;
	logic                      adc_start_r;
	logic [5:0]                pin_out_r;
	wire                       acc_phase;
	wire                       wr;
	wire                       hit_any;
	wire  [31:0]               rd_word;
	ccmc_pkg::ccmc_ctrl_type   ctrl_q   [2];
	logic [15:0]               data_q   [2];
	logic                      pin_q    [2];
	logic                      oe_q     [2];
	logic                      use3     [2];
	logic                      trig     [2];
	logic                      ev_set   [2];
	logic                      in_now   [2];

	assign acc_phase = psel_i & penable_i & pready_r;
	assign wr        = acc_phase & pwrite_i;
	assign hit_any   = (paddr_i[1:0] == 2'b00) && (paddr_i <= ccmc_pkg::OFF_STAT);

	// Reading control shows only the low six bits; bits 7 and 6 stay zero. (see RULE_06)
	assign rd_word = (paddr_i == ccmc_pkg::OFF_U1_CTRL) ? {26'h0, ctrl_q[0]} :
	                 (paddr_i == ccmc_pkg::OFF_U1_DLO)  ? {24'h0, data_q[0][7:0]} :
	                 (paddr_i == ccmc_pkg::OFF_U1_DHI)  ? {24'h0, data_q[0][15:8]} :
	                 (paddr_i == ccmc_pkg::OFF_U2_CTRL) ? {26'h0, ctrl_q[1]} :
	                 (paddr_i == ccmc_pkg::OFF_U2_DLO)  ? {24'h0, data_q[1][7:0]} :
	                 (paddr_i == ccmc_pkg::OFF_U2_DHI)  ? {24'h0, data_q[1][15:8]} :
	                 (paddr_i == ccmc_pkg::OFF_CFG)     ? {29'h0, route_r, cfg_tb_r} :
	                 (paddr_i == ccmc_pkg::OFF_STAT)    ? {29'h0, stat_r} : 32'h0;

	// Every access takes one wait state so that read data comes from a flip-flop.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= psel_i & penable_i & ~pready_r;
			prdata_r  <= (psel_i & penable_i & ~pready_r & ~pwrite_i) ? rd_word : 32'h0;
			pslverr_r <= psel_i & penable_i & ~pready_r & ~hit_any;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cfg_tb_r <= ccmc_pkg::CFG_RESET[1:0];
			route_r  <= ccmc_pkg::CFG_RESET[ccmc_pkg::CFG_ROUTE_BIT];
		end else if (wr && paddr_i == ccmc_pkg::OFF_CFG) begin
			cfg_tb_r <= pwdata_i[ccmc_pkg::CFG_TB_LSB +: 2];
			route_r  <= pwdata_i[ccmc_pkg::CFG_ROUTE_BIT];
		end
	end

	// Flags are write-one-to-clear and a set in the same cycle wins. (see RULE_24)
	// The overflow flag is set by the counter's own wrap only, never by a trigger clear. (see RULE_04)
	wire [2:0] stat_set = {counter_three_wrap_i, ev_set[1], ev_set[0]};
	wire [2:0] stat_clr = (wr && paddr_i == ccmc_pkg::OFF_STAT) ? pwdata_i[2:0] : 3'h0;
	always_ff @(posedge clk_i) begin
		if (srst_i)
			stat_r <= 3'h0;
		else
			stat_r <= stat_set | (stat_r & ~stat_clr);
	end

	// Pins are synchronised before the route selects one, so the mux never sees a raw input.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end else begin
			pin_meta_r <= {alternate_port_pin_i, default_port_pin_i, unit_one_pin_i};
			pin_sync_r <= pin_meta_r;
		end
	end
	assign in_now[0] = pin_sync_r[0];
	assign in_now[1] = route_r ? pin_sync_r[1] : pin_sync_r[2]; // see RULE_19

	for (genvar u = 0; u < 2; u++) begin : g_unit
		ccmc_pkg::ccmc_ctrl_type ctrl_r;
		logic [15:0]             data_r;
		logic [9:0]              shadow_r;
		logic [9:0]              shadow_nxt;
		logic                    pin_r;
		logic                    pin_nxt;
		logic [3:0]              presc_r;
		logic [3:0]              presc_nxt;
		logic [3:0]              mode_prev_r;
		logic                    match_prev_r;
		logic                    in_prev_r;
		wire  [3:0]              mode       = ctrl_r.mode;
		wire  ccmc_pkg::ccmc_op_type op     = ccmc_pkg::op_of(mode);
		wire                     is_two     = (u == 1);
		wire                     wr_ctrl    = wr && paddr_i == (is_two ? ccmc_pkg::OFF_U2_CTRL : ccmc_pkg::OFF_U1_CTRL);
		wire                     wr_dlo     = wr && paddr_i == (is_two ? ccmc_pkg::OFF_U2_DLO : ccmc_pkg::OFF_U1_DLO);
		wire                     wr_dhi     = wr && paddr_i == (is_two ? ccmc_pkg::OFF_U2_DHI : ccmc_pkg::OFF_U1_DHI);
		wire                     sel3       = ccmc_pkg::uses_three(cfg_tb_r, is_two); // see RULE_23
		wire  [15:0]             tb_val     = sel3 ? counter_three_i : counter_one_i; // see RULE_16
		wire                     rise       = in_now[u] & ~in_prev_r;
		wire                     fall       = ~in_now[u] & in_prev_r;
		wire                     cap_r4     = (mode == ccmc_pkg::MODE_CAP_R4);
		wire                     cap_r16    = (mode == ccmc_pkg::MODE_CAP_R16);
		wire  [3:0]              presc_last = cap_r4 ? ccmc_pkg::PRESC4_LAST : ccmc_pkg::PRESC16_LAST;
		wire                     match      = (op == ccmc_pkg::OP_COMPARE) && (data_r == tb_val);
		wire                     match_hit  = match & ~match_prev_r;
		wire                     entered    = (mode != mode_prev_r);
		wire  [9:0]              duty_new   = {data_r[7:0], ctrl_r.duty_low}; // see RULE_07
		logic                    cap_fire;

		// Capture edge choice: falling, rising, or every fourth or sixteenth rise. (see RULE_10)
		always_comb begin
			cap_fire  = 1'b0;
			presc_nxt = 4'h0;
			if (op == ccmc_pkg::OP_CAPTURE) begin
				presc_nxt = presc_r;
				if (mode == ccmc_pkg::MODE_CAP_FALL)
					cap_fire = fall;
				else if (mode == ccmc_pkg::MODE_CAP_RISE)
					cap_fire = rise;
				else if (rise && (cap_r4 || cap_r16)) begin
					cap_fire  = (presc_r == presc_last);
					presc_nxt = cap_fire ? 4'h0 : presc_r + 4'h1;
				end
			end
		end

		// Pin latch per mode; a zero mode returns it to its reset level. (see RULE_08)
		always_comb begin
			pin_nxt    = pin_r;
			shadow_nxt = shadow_r;
			if (mode == ccmc_pkg::MODE_OFF) begin
				pin_nxt    = 1'b0;
				shadow_nxt = 10'h0;
			end else if (op == ccmc_pkg::OP_PWM) begin
				// Period and update come from the one counter-two match for both units. (see RULE_22)
				if (counter_two_match_i) begin
					shadow_nxt = duty_new;
					pin_nxt    = (duty_new != 10'h0);
				end else if (counter_two_i == shadow_r) begin
					pin_nxt = 1'b0;
				end
			end else if (entered && mode == ccmc_pkg::MODE_CMP_SET) begin
				pin_nxt = 1'b0; // see RULE_11
			end else if (entered && mode == ccmc_pkg::MODE_CMP_CLR) begin
				pin_nxt = 1'b1; // see RULE_12
			end else if (match_hit) begin
				if (mode == ccmc_pkg::MODE_TOGGLE)
					pin_nxt = ~pin_r; // see RULE_09
				else if (mode == ccmc_pkg::MODE_CMP_SET)
					pin_nxt = 1'b1; // see RULE_11
				else if (mode == ccmc_pkg::MODE_CMP_CLR)
					pin_nxt = 1'b0; // see RULE_12
			end
		end

		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				ctrl_r       <= '0;
				mode_prev_r  <= 4'h0;
				match_prev_r <= 1'b0;
				in_prev_r    <= 1'b0;
				presc_r      <= 4'h0;
				pin_r        <= 1'b0;
				shadow_r     <= 10'h0;
			end else begin
				if (wr_ctrl)
					ctrl_r <= ccmc_pkg::ccmc_ctrl_type'(pwdata_i[5:0]);
				mode_prev_r  <= mode;
				match_prev_r <= match;
				in_prev_r    <= in_now[u];
				presc_r      <= presc_nxt;
				pin_r        <= pin_nxt;
				shadow_r     <= shadow_nxt;
			end
		end

		// One 16-bit register per unit; a capture overwrites any unread value. (see RULE_05)
		always_ff @(posedge clk_i) begin
			if (srst_i)
				data_r <= 16'h0;
			else if (cap_fire)
				data_r <= tb_val; // see RULE_24
			else if (wr_dlo)
				data_r[7:0] <= pwdata_i[7:0];
			else if (wr_dhi)
				data_r[15:8] <= pwdata_i[7:0];
		end

		assign ctrl_q[u] = ctrl_r;
		assign data_q[u] = data_r;
		assign pin_q[u]  = pin_r;
		// The software-only and trigger modes leave the pin to the port. (see RULE_13)
		assign oe_q[u]   = (op == ccmc_pkg::OP_PWM) || mode == ccmc_pkg::MODE_TOGGLE ||
		                   mode == ccmc_pkg::MODE_CMP_SET || mode == ccmc_pkg::MODE_CMP_CLR;
		assign use3[u]   = sel3;
		assign trig[u]   = match_hit && mode == ccmc_pkg::MODE_CMP_TRIG; // see RULE_14
		assign ev_set[u] = cap_fire | match_hit;
	end

	// Either unit clears its own time base; PWM never reaches counters one or three. (see RULE_15)
	// A coincident software write to counter three keeps its value. (see RULE_03)
	wire clr1 = (trig[0] & ~use3[0]) | (trig[1] & ~use3[1]);
	wire clr3 = ((trig[0] & use3[0]) | (trig[1] & use3[1])) & ~counter_three_write_i; // see RULE_01
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctr1_clear_r <= 1'b0;
			ctr3_clear_r <= 1'b0;
			adc_start_r  <= 1'b0;
		end else begin
			ctr1_clear_r <= clr1; // see RULE_17
			ctr3_clear_r <= clr3;
			adc_start_r  <= trig[1] & adc_enabled_i; // see RULE_21
		end
	end

	// Registered pin drive; unit two appears only on the pin the route bit names. (see RULE_19)
	always_ff @(posedge clk_i) begin
		if (srst_i)
			pin_out_r <= 6'h0;
		else
			pin_out_r <= {pin_q[0], oe_q[0],
			              pin_q[1] & route_r, oe_q[1] & route_r,
			              pin_q[1] & ~route_r, oe_q[1] & ~route_r};
	end

	assign prdata_o                      = prdata_r;
	assign pready_o                      = pready_r;
	assign pslverr_o                     = pslverr_r;
	assign unit_one_pin_o                = pin_out_r[5];
	assign unit_one_pin_oe_o             = pin_out_r[4];
	assign default_port_pin_o            = pin_out_r[3];
	assign default_port_pin_oe_o         = pin_out_r[2];
	assign alternate_port_pin_o          = pin_out_r[1];
	assign alternate_port_pin_oe_o       = pin_out_r[0];
	assign counter_one_clear_o           = ctr1_clear_r;
	assign counter_three_clear_o         = ctr3_clear_r;
	assign adc_start_o                   = adc_start_r;
	assign counter_three_overflow_flag_o = stat_r[ccmc_pkg::STAT_OVF3_BIT];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_two_trig_on_three;
		trig[1] && use3[1] && !counter_three_write_i;
	endsequence
	sequence s_three_cleared;
		counter_three_clear_o ##1 !counter_three_clear_o || counter_three_clear_o;
	endsequence

	a_trig_clears_three: assert property (s_two_trig_on_three |=> s_three_cleared) // see RULE_01
		else $error("unit two trigger did not clear counter three");
	a_adc_start_gate: assert property (adc_start_o |-> $past(trig[1]) && $past(adc_enabled_i)) // see RULE_21
		else $error("conversion start without enabled unit two trigger");
	a_write_beats_clear: assert property (counter_three_write_i |=> !counter_three_clear_o) // see RULE_03
		else $error("counter three clear issued over a write");
	a_trig_no_overflow: assert property (trig[1] && !counter_three_wrap_i &&
		!stat_r[ccmc_pkg::STAT_OVF3_BIT] |=> !counter_three_overflow_flag_o) // see RULE_04
		else $error("trigger set the counter three overflow flag");
	a_ctrl_top_zero: assert property (pready_o && $past(!pwrite_i && (paddr_i == ccmc_pkg::OFF_U1_CTRL ||
		paddr_i == ccmc_pkg::OFF_U2_CTRL)) |-> prdata_o[7:6] == 2'b00) // see RULE_06
		else $error("control bits 7 and 6 read non-zero");
	a_off_resets_pin: assert property (ctrl_q[0].mode == ccmc_pkg::MODE_OFF |=>
		!pin_q[0] && g_unit[0].presc_r == 4'h0) // see RULE_08
		else $error("mode zero left unit one state active");
	a_toggle_inverts: assert property (g_unit[0].match_hit && ctrl_q[0].mode == ccmc_pkg::MODE_TOGGLE &&
		$stable(ctrl_q[0]) |=> pin_q[0] != $past(pin_q[0]) && stat_r[ccmc_pkg::STAT_EV1_BIT]) // see RULE_09
		else $error("toggle compare did not invert pin and set flag");
	a_capture_loads: assert property (g_unit[0].cap_fire |=> data_q[0] == $past(g_unit[0].tb_val) &&
		stat_r[ccmc_pkg::STAT_EV1_BIT]) // see RULE_24
		else $error("capture did not load value and set flag");
	a_set_high_match: assert property (g_unit[1].match_hit && ctrl_q[1].mode == ccmc_pkg::MODE_CMP_SET &&
		!g_unit[1].entered |=> pin_q[1] ##1 (default_port_pin_o || alternate_port_pin_o)) // see RULE_11
		else $error("set-on-match did not drive unit two pin high");
	a_pwm_period_high: assert property (ctrl_q[0].mode[3:2] == 2'b11 && counter_two_match_i &&
		g_unit[0].duty_new != 10'h0 |=> pin_q[0] ##1 unit_one_pin_o && unit_one_pin_oe_o) // see RULE_22
		else $error("PWM period did not raise unit one pin");
	a_route_exclusive: assert property (!(default_port_pin_oe_o && alternate_port_pin_oe_o)) // see RULE_19
		else $error("unit two drives both port pins");
endmodule // ccmc_top
`default_nettype wire

// [include/ccmc_pkg.sv]
/*
 * Constants, types and helper functions for the capture/compare mode and configuration block.
 * Assumes an APB register bus with 32-bit data and an 8-bit byte address.
 */
package ccmc_pkg;
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFF_U1_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_U1_DLO    = 8'h04;
	localparam logic [7:0]  OFF_U1_DHI    = 8'h08;
	localparam logic [7:0]  OFF_U2_CTRL   = 8'h0c;
	localparam logic [7:0]  OFF_U2_DLO    = 8'h10;
	localparam logic [7:0]  OFF_U2_DHI    = 8'h14;
	localparam logic [7:0]  OFF_CFG       = 8'h18;
	localparam logic [7:0]  OFF_STAT      = 8'h1c;
	localparam int          CFG_TB_LSB    = 0;
	localparam int          CFG_ROUTE_BIT = 2;
	localparam logic [2:0]  CFG_RESET     = 3'h4;
	localparam int          STAT_EV1_BIT  = 0;
	localparam int          STAT_EV2_BIT  = 1;
	localparam int          STAT_OVF3_BIT = 2;
	localparam logic [3:0]  MODE_OFF      = 4'h0;
	localparam logic [3:0]  MODE_TOGGLE   = 4'h2;
	localparam logic [3:0]  MODE_CAP_FALL = 4'h4;
	localparam logic [3:0]  MODE_CAP_RISE = 4'h5;
	localparam logic [3:0]  MODE_CAP_R4   = 4'h6;
	localparam logic [3:0]  MODE_CAP_R16  = 4'h7;
	localparam logic [3:0]  MODE_CMP_SET  = 4'h8;
	localparam logic [3:0]  MODE_CMP_CLR  = 4'h9;
	localparam logic [3:0]  MODE_CMP_SOFT = 4'ha;
	localparam logic [3:0]  MODE_CMP_TRIG = 4'hb;
	localparam logic [3:0]  PRESC4_LAST   = 4'h3;
	localparam logic [3:0]  PRESC16_LAST  = 4'hf;

	typedef enum logic [1:0] {OP_IDLE, OP_CAPTURE, OP_COMPARE, OP_PWM} ccmc_op_type;

	typedef struct packed {
		logic [1:0] duty_low;
		logic [3:0] mode;
	} ccmc_ctrl_type;

	function automatic ccmc_op_type op_of(input logic [3:0] mode);
		if (mode[3:2] == 2'b11)
			return OP_PWM;
		else if (mode[3:2] == 2'b01)
			return OP_CAPTURE;
		else if (mode[3] || mode == MODE_TOGGLE)
			return OP_COMPARE;
		else
			return OP_IDLE;
	endfunction

	function automatic logic uses_three(input logic [1:0] assign_field, input logic is_unit_two);
		return assign_field[1] | (assign_field[0] & is_unit_two);
	endfunction
endpackage

// [dv/ccmc_far_side.sv]
/* Behavioural timers beside the capture/compare block: counters one, two and three.
 * Assumes the bench drives run and load on clk_i; a load also stands for a software write to counter three. */
`timescale 1ns/1ns
`default_nettype none
module ccmc_far_side #(
	parameter logic [9:0] PERIOD = 10'h03f
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        run_i,
	input  wire logic        load_i,
	input  wire logic [15:0] load_val_i,
	input  wire logic        c1_clear_i,
	input  wire logic        c3_clear_i,
	output logic      [15:0] c1_o,
	output logic      [15:0] c3_o,
	output logic      [9:0]  c2_o,
	output logic             c2_match_o,
	output logic             c3_write_o,
	output logic             c3_wrap_o
);
	assign c3_write_o = load_i;
	assign c2_match_o = (c2_o == PERIOD);
	// Counting stays synchronous to clk_i, so clears and captures are reliable.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			c1_o      <= 16'h0000;
			c3_o      <= 16'h0000;
			c2_o      <= 10'h000;
			c3_wrap_o <= 1'b0;
		end else begin
			c1_o      <= load_i ? load_val_i : c1_clear_i ? 16'h0000 : c1_o + {15'h0000, run_i};
			c3_o      <= load_i ? load_val_i : c3_clear_i ? 16'h0000 : c3_o + {15'h0000, run_i};
			c3_wrap_o <= run_i & ~load_i & ~c3_clear_i & (c3_o == 16'hffff);
			c2_o      <= c2_match_o ? 10'h000 : c2_o + 10'h001;
		end
	end
endmodule // ccmc_far_side
`default_nettype wire

// [dv/tb_ccmc_top.sv]
/* Self-checking bench for the capture/compare mode block, driven over APB.
 * Assumes the timer model of ccmc_far_side and a pull-down on both unit-two pins. */
`timescale 1ns/1ns
`default_nettype none
module tb_ccmc_top;
	localparam logic [9:0] PER = 10'h03f;
	logic        clk_i, srst_i, psel, penable, pwrite, pready, pslverr, er, run, load, adc_en, pin1_tb;
	logic        c2_match, c3_write, c3_wrap, pin1_o, pin1_oe, dpin_o, dpin_oe, apin_o, apin_oe;
	logic        c1_clr, c3_clr, adc_start, ovf;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] c1, c3, load_val;
	logic [9:0]  c2;
	int          num_errors, comparisons, n_c1, n_c3, n_adc, b1, b3, ba, h1, h2;
	logic [6:0]  trg [6] = '{7'h3b, 7'h32, 7'h1d, 7'h0c, 7'h4a, 7'h2c};
	logic [7:0]  cmp [6] = '{8'h8b, 8'h9d, 8'h2b, 8'ha1, 8'h10, 8'h30};
	int          caps [4] = '{1, 1, 4, 16};

	ccmc_top ccmc_top_inst (.clk_i(clk_i), .srst_i(srst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.counter_one_i(c1), .counter_three_i(c3), .counter_two_i(c2), .counter_two_match_i(c2_match),
		.counter_three_write_i(c3_write), .counter_three_wrap_i(c3_wrap), .adc_enabled_i(adc_en),
		.unit_one_pin_i(pin1_oe ? pin1_o : pin1_tb), .default_port_pin_i(dpin_oe & dpin_o),
		.alternate_port_pin_i(apin_oe & apin_o), .unit_one_pin_o(pin1_o), .unit_one_pin_oe_o(pin1_oe),
		.default_port_pin_o(dpin_o), .default_port_pin_oe_o(dpin_oe), .alternate_port_pin_o(apin_o),
		.alternate_port_pin_oe_o(apin_oe), .counter_one_clear_o(c1_clr), .counter_three_clear_o(c3_clr),
		.adc_start_o(adc_start), .counter_three_overflow_flag_o(ovf));
	ccmc_far_side #(.PERIOD(PER)) ccmc_far_side_inst (.clk_i(clk_i), .srst_i(srst_i), .run_i(run), .load_i(load),
		.load_val_i(load_val), .c1_clear_i(c1_clr), .c3_clear_i(c3_clr), .c1_o(c1), .c3_o(c3), .c2_o(c2),
		.c2_match_o(c2_match), .c3_write_o(c3_write), .c3_wrap_o(c3_wrap));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Pulse tallies only grow, so tests compare against a snapshot instead of clearing them.
	always @(posedge clk_i) begin
		n_c1 <= n_c1 + int'(c1_clr);
		n_c3 <= n_c3 + int'(c3_clr);
		n_adc <= n_adc + int'(adc_start);
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk("pready", 32'h1, 32'h0);
		@(posedge clk_i);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task ld(input logic [15:0] v);
		load <= 1'b1;
		load_val <= v;
		@(posedge clk_i);
		load <= 1'b0;
	endtask
	task edge_pulse;
		pin1_tb <= ~pin1_tb;
		cyc(4);
		pin1_tb <= ~pin1_tb;
		cyc(4);
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#(50 * 40000);
		num_errors++;
		results();
	end

	initial begin
		{psel, penable, pwrite, run, load, adc_en, pin1_tb} = 7'h00;
		{paddr, pwdata, load_val} = 56'h0;
		{num_errors, comparisons, n_c1, n_c3, n_adc} = 160'h0;
		srst_i = 1'b1;
		cyc(4);
		srst_i <= 1'b0;
		@(posedge clk_i);
		rdc("cfg reset", ccmc_pkg::OFF_CFG, 32'h4);
		wr(ccmc_pkg::OFF_U1_CTRL, 32'hf0);
		rdc("ctrl upper bits", ccmc_pkg::OFF_U1_CTRL, 32'h30);
		wr(ccmc_pkg::OFF_U2_DLO, 32'ha5);
		wr(ccmc_pkg::OFF_U2_DHI, 32'h5a);
		rdc("data low", ccmc_pkg::OFF_U2_DLO, 32'ha5);
		rdc("data high", ccmc_pkg::OFF_U2_DHI, 32'h5a);
		rdc("unmapped read", 8'h20, 32'h0);
		chk("unmapped error", 32'h1, 32'(er));
		$display("test registers done");
		wr(ccmc_pkg::OFF_U1_DLO, 32'h10);
		wr(ccmc_pkg::OFF_U1_DHI, 32'h0);
		wr(ccmc_pkg::OFF_U2_DLO, 32'h10);
		wr(ccmc_pkg::OFF_U2_DHI, 32'h0);
		run <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			wr(ccmc_pkg::OFF_U1_CTRL, 32'h0);
			wr(ccmc_pkg::OFF_U2_CTRL, 32'h0);
			wr(ccmc_pkg::OFF_STAT, 32'h7);
			wr(ccmc_pkg::OFF_CFG, {29'h0, 1'b1, trg[i][6:5]});
			adc_en <= trg[i][3];
			ld(16'h0000);
			b1 = n_c1;
			b3 = n_c3;
			ba = n_adc;
			wr(trg[i][4] ? ccmc_pkg::OFF_U2_CTRL : ccmc_pkg::OFF_U1_CTRL, {28'h0, ccmc_pkg::MODE_CMP_TRIG});
			cyc(100);
			chk("counter one clears", 32'(trg[i][2]), 32'(n_c1 > b1));
			chk("counter three clears", 32'(trg[i][1]), 32'(n_c3 > b3));
			chk("conversion starts", 32'(trg[i][0]), 32'(n_adc > ba));
			chk("overflow flag", 32'h0, 32'(ovf));
			rdc("event flag", ccmc_pkg::OFF_STAT, trg[i][4] ? 32'h2 : 32'h1);
		end
		wr(ccmc_pkg::OFF_U1_CTRL, 32'h0);
		wr(ccmc_pkg::OFF_U2_CTRL, 32'h0);
		wr(ccmc_pkg::OFF_STAT, 32'h7);
		ld(16'hfff0);
		cyc(30);
		chk("wrap sets overflow", 32'h1, 32'(ovf));
		wr(ccmc_pkg::OFF_STAT, 32'h4);
		rdc("overflow cleared", ccmc_pkg::OFF_STAT, 32'h0);
		$display("test trigger done");
		wr(ccmc_pkg::OFF_CFG, 32'h4);
		for (int i = 0; i < 6; i++) begin
			wr(ccmc_pkg::OFF_U1_CTRL, {28'h0, cmp[i][7:4]});
			cyc(3);
			chk("pin enable", 32'(cmp[i][3]), 32'(pin1_oe));
			if (cmp[i][3])
				chk("pin start", 32'(cmp[i][2]), 32'(pin1_o));
			ld(16'h0000);
			cyc(30);
			if (cmp[i][3])
				chk("pin after match", 32'(cmp[i][1]), 32'(pin1_o));
			rdc("event flag", ccmc_pkg::OFF_STAT, 32'(cmp[i][0]));
			wr(ccmc_pkg::OFF_STAT, 32'h7);
			wr(ccmc_pkg::OFF_U1_CTRL, 32'h0);
			cyc(3);
			chk("pin off", 32'h0, 32'(pin1_o));
		end
		$display("test compare done");
		run <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(ccmc_pkg::OFF_U1_CTRL, 32'h0);
			pin1_tb <= (i == 0);
			wr(ccmc_pkg::OFF_U1_DLO, 32'h0);
			wr(ccmc_pkg::OFF_U1_DHI, 32'h0);
			wr(ccmc_pkg::OFF_STAT, 32'h7);
			wr(ccmc_pkg::OFF_U1_CTRL, {28'h0, 4'(i + 4)});
			ld(16'h1111);
			repeat (caps[i] - 1) edge_pulse();
			rdc("no capture yet", ccmc_pkg::OFF_U1_DLO, 32'h0);
			ld(16'hc35a);
			edge_pulse();
			rdc("captured high", ccmc_pkg::OFF_U1_DHI, 32'hc3);
			rdc("captured low", ccmc_pkg::OFF_U1_DLO, 32'h5a);
			rdc("capture flag", ccmc_pkg::OFF_STAT, 32'h1);
		end
		$display("test capture done");
		wr(ccmc_pkg::OFF_U1_CTRL, 32'h0);
		wr(ccmc_pkg::OFF_U2_CTRL, {28'h0, ccmc_pkg::MODE_CMP_SET});
		cyc(3);
		chk("default pin enable", 32'h1, 32'(dpin_oe));
		chk("alternate pin idle", 32'h0, 32'(apin_oe));
		chk("default pin start", 32'h0, 32'(dpin_o));
		ld(16'h0010);
		cyc(3);
		chk("default pin after match", 32'h1, 32'(dpin_o));
		wr(ccmc_pkg::OFF_CFG, 32'h0);
		cyc(3);
		chk("default pin idle", 32'h0, 32'(dpin_oe));
		chk("alternate pin enable", 32'h1, 32'(apin_oe));
		chk("alternate pin after match", 32'h1, 32'(apin_o));
		wr(ccmc_pkg::OFF_CFG, 32'h4);
		$display("test route done");
		wr(ccmc_pkg::OFF_U1_DLO, 32'h02);
		wr(ccmc_pkg::OFF_U1_CTRL, 32'h1c);
		wr(ccmc_pkg::OFF_U2_DLO, 32'h05);
		wr(ccmc_pkg::OFF_U2_CTRL, 32'h0f);
		cyc(140);
		h1 = 0;
		h2 = 0;
		repeat (128) begin
			@(posedge clk_i);
			h1 += int'(pin1_o);
			h2 += int'(dpin_o);
		end
		chk("pwm one high cycles", 32'h14, 32'(h1));
		chk("pwm two high cycles", 32'h2a, 32'(h2));
		chk("pwm pin enable", 32'h1, 32'(pin1_oe & dpin_oe));
		$display("test pwm done");
		results();
	end
endmodule // tb_ccmc_top
`default_nettype wire
